// ===== design/wss_top.sv
// Output stage of a four-output complementary waveform generator.
// Assumes an APB master on clock_in and asynchronous wave and fault inputs.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Fall dead band buffered; written directly while disabled.
// - Load request moves buffer at input falling edge.
// - Fall count delays b (half), d (full).
// - Too-short input pulse gives no output pulse.
// - Dead band jitter at most one clock.
// - Direction bit applies at next input rise.
// - Direction change: a/c switch, modulated held.
// - Steering modes route input to any outputs.
// - Steer bit zero holds fixed level.
// - Polarity acts only on steered outputs.
// - Steering shutdown overrides only steered outputs.
// - Mode 000 applies steer bits immediately.
// - Mode 001 applies steer bits at rise.
// - Software shutdown bit holds shutdown state while auto-restart is off.
// - Selected active-low fault forces override levels.
// - Faults are levels; shutdown holds while present.
// - Keeps internal oscillator request while running.
// - Pair override one/zero levels ignore polarity; inactive follows it.
// - Software clear refused while a fault persists.
// - Auto-restart clears; overrides end at rise.
// - Three-bit mode field selects operation.
// - Two-bit override field encoding.
// - Load request self-clears; needs prior enable.
module wss_top
   import wss_pkg::*;
(
   input  wire logic                         clock_in,
   input  wire logic                         rst_in,
   input  wire logic                         psel_in,
   input  wire logic                         penable_in,
   input  wire logic                         pwrite_in,
   input  wire logic [wss_pkg::ADDR_W-1:0]   paddr_in,
   input  wire logic [wss_pkg::DATA_W-1:0]   pwdata_in,
   output logic      [wss_pkg::DATA_W-1:0]   prdata_out,
   output logic                              pready_out,
   output logic                              pslverr_out,
   input  wire logic [wss_pkg::NUM_WAVE-1:0] wave_sources_in,
   input  wire logic [wss_pkg::NUM_SD-2:0]   shutdown_sources_n_in,
   output logic      [wss_pkg::NUM_OUT-1:0]  out_level_out,
   output logic      [wss_pkg::NUM_OUT-1:0]  out_oe_out,
   output logic                              osc_keep_request_out
);
   import wss_pkg::*;

   // ==========================================================
   // Register storage
   // ==========================================================
   logic              en;
   logic              load_req;
   wss_mode_e         mode;
   logic [3:0]        polarity;
   logic [DB_W-1:0]   rise_buf;
   logic [DB_W-1:0]   rise_act;
   logic [DB_W-1:0]   fall_buf;
   logic [DB_W-1:0]   fall_act;
   logic              sd_status;
   logic              restart_en;
   logic [1:0]        ovr_bd;
   logic [1:0]        ovr_ac;
   logic [NUM_SD-1:0] sd_select;
   logic [7:0]        steer;
   logic [3:0]        out_enable;
   logic              clk_hf;
   logic [SEL_W-1:0]  in_select;

   // ==========================================================
   // Bus decode
   // ==========================================================
   wire access    = psel_in & penable_in;
   wire wr        = access & pwrite_in;
   wire hit_c0    = paddr_in == OFF_CONTROL0;
   wire hit_pol   = paddr_in == OFF_POLARITY;
   wire hit_rdb   = paddr_in == OFF_RISE_DB;
   wire hit_fdb   = paddr_in == OFF_FALL_DB;
   wire hit_sd0   = paddr_in == OFF_SD_CTRL0;
   wire hit_sds   = paddr_in == OFF_SD_SOURCE;
   wire hit_str   = paddr_in == OFF_STEER;
   wire hit_oen   = paddr_in == OFF_OUT_ENABLE;
   wire hit_clk   = paddr_in == OFF_CLK_SELECT;
   wire hit_ism   = paddr_in == OFF_IN_SELECT;
   wire mapped    = hit_c0 | hit_pol | hit_rdb | hit_fdb | hit_sd0
                  | hit_sds | hit_str | hit_oen | hit_clk | hit_ism;
   wire wr_c0     = wr & hit_c0;
   wire wr_sd0    = wr & hit_sd0;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [NUM_WAVE-1:0] wave_meta;
   logic [NUM_WAVE-1:0] wave_sync;
   logic [NUM_SD-2:0]   sd_meta;
   logic [NUM_SD-2:0]   sd_sync;

   always_ff @(posedge clock_in)
   begin
      wave_meta <= wave_sources_in;
      wave_sync <= wave_meta;
      sd_meta   <= shutdown_sources_n_in;
      sd_sync   <= sd_meta;
   end

   // ==========================================================
   // Input selection and edges
   // ==========================================================
   logic wave_prev;
   wire  wave     = wave_sync[in_select];
   wire  rise     = wave & ~wave_prev;
   wire  fall     = ~wave & wave_prev;
   wire  is_full  = mode == WSS_FWD_FULL || mode == WSS_REV_FULL;
   wire  is_steer = mode == WSS_STEER || mode == WSS_SYNC_STEER;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         wave_prev <= 1'b0;
      else
         wave_prev <= wave;
   end

   // ==========================================================
   // Shutdown detection
   // ==========================================================
   // Source 5 is the wave input pin, the others come from the port.
   wire [NUM_SD-1:0] sd_levels_n = {wave_sync[0], sd_sync};
   wire fault = |(sd_select & ~sd_levels_n);
   wire sw_set_sd   = wr_sd0 & pwdata_in[BIT_SHUTDOWN];
   wire sw_clr_sd   = wr_sd0 & ~pwdata_in[BIT_SHUTDOWN];
   wire auto_clr_sd = restart_en & ~fault;
   // Set always wins over any clear, and a fault blocks clearing.
   wire next_sd = sw_set_sd | fault
                | (sd_status & ~((sw_clr_sd | auto_clr_sd) & ~fault));
   logic override_on;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         override_on <= 1'b0;
      else if (next_sd)
         override_on <= 1'b1;
      else if (rise)
         override_on <= 1'b0;
   end

   // ==========================================================
   // Control register writes
   // ==========================================================
   wire next_en    = wr_c0 ? pwdata_in[BIT_EN] : en;
   wire ld_set     = wr_c0 & pwdata_in[BIT_LD] & en & next_en;
   wire ld_fire    = load_req & fall & en;

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         en         <= 1'b0;
         load_req   <= 1'b0;
         mode       <= WSS_STEER;
         polarity   <= 4'h0;
         sd_status  <= 1'b0;
         restart_en <= 1'b0;
         ovr_bd     <= RST_OVR_LEVEL;
         ovr_ac     <= RST_OVR_LEVEL;
         sd_select  <= '0;
         steer      <= 8'h00;
         out_enable <= 4'h0;
         clk_hf     <= 1'b0;
         in_select  <= '0;
      end
      else
      begin
         en        <= next_en;
         load_req  <= ld_set | (load_req & ~ld_fire & next_en);
         sd_status <= next_sd;
         if (wr_c0)
            mode <= wss_mode_e'(pwdata_in[2:0]);
         if (wr & hit_pol)
            polarity <= pwdata_in[3:0];
         if (wr_sd0)
         begin
            restart_en <= pwdata_in[BIT_REN];
            ovr_bd     <= pwdata_in[POS_OVERRIDE_LEVEL_BD +: 2];
            ovr_ac     <= pwdata_in[POS_OVERRIDE_LEVEL_AC +: 2];
         end
         if (wr & hit_sds)
            sd_select <= pwdata_in[NUM_SD-1:0];
         if (wr & hit_str)
            steer <= pwdata_in[7:0];
         if (wr & hit_oen)
            out_enable <= pwdata_in[3:0];
         if (wr & hit_clk)
            clk_hf <= pwdata_in[0];
         if (wr & hit_ism)
            in_select <= pwdata_in[SEL_W-1:0];
      end
   end

   // ==========================================================
   // Dead-band value buffers
   // ==========================================================
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         rise_buf <= RST_DB;
         rise_act <= RST_DB;
         fall_buf <= RST_DB;
         fall_act <= RST_DB;
      end
      else
      begin
         if (wr & hit_rdb)
            rise_buf <= pwdata_in[DB_W-1:0];
         if (wr & hit_fdb)
            fall_buf <= pwdata_in[DB_W-1:0];
         if (wr & hit_rdb & ~en)
            rise_act <= pwdata_in[DB_W-1:0];
         else if (ld_fire)
            rise_act <= rise_buf;
         if (wr & hit_fdb & ~en)
            fall_act <= pwdata_in[DB_W-1:0];
         else if (ld_fire)
            fall_act <= fall_buf;
      end
   end

   // ==========================================================
   // Direction and steering latches
   // ==========================================================
   logic       dir_rev;
   logic       dir_valid;
   logic [3:0] steer_sync;
   wire  dir_req   = mode == WSS_REV_FULL;
   wire  dir_chg   = rise & is_full & (dir_req != dir_rev | ~dir_valid);

   always_ff @(posedge clock_in)
   begin
      if (rst_in | ~en)
      begin
         dir_rev   <= 1'b0;
         dir_valid <= 1'b0;
      end
      else if (rise & is_full)
      begin
         dir_rev   <= dir_req;
         dir_valid <= 1'b1;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         steer_sync <= 4'h0;
      else if (rise)
         steer_sync <= steer[3:0];
   end

   wire [3:0] steer_act = mode == WSS_STEER ? steer[3:0]
                                            : steer_sync;

   // ==========================================================
   // Dead-band counters
   // ==========================================================
   logic [DB_W-1:0] fall_cnt;
   logic            fall_wait;
   logic [DB_W-1:0] rise_cnt;
   logic            rise_wait;
   wire  fall_trig = mode == WSS_HALF ? fall
                                      : dir_chg & ~dir_req;
   wire  rise_trig = mode == WSS_HALF ? rise : dir_chg & dir_req;

   always_ff @(posedge clock_in)
   begin
      if (rst_in | ~en)
      begin
         fall_cnt  <= '0;
         fall_wait <= 1'b0;
      end
      else if (fall_trig)
      begin
         fall_cnt  <= 6'h01;
         fall_wait <= fall_act != RST_DB;
      end
      else if (fall_wait)
      begin
         fall_cnt  <= fall_cnt + 6'h01;
         fall_wait <= fall_cnt != fall_act;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in | ~en)
      begin
         rise_cnt  <= '0;
         rise_wait <= 1'b0;
      end
      else if (rise_trig)
      begin
         rise_cnt  <= 6'h01;
         rise_wait <= rise_act != RST_DB;
      end
      else if (rise_wait)
      begin
         rise_cnt  <= rise_cnt + 6'h01;
         rise_wait <= rise_cnt != rise_act;
      end
   end

   // ==========================================================
   // Push-pull sequencer
   // ==========================================================
   logic pp_second;

   always_ff @(posedge clock_in)
   begin
      if (rst_in | ~en | override_on)
         pp_second <= 1'b0;
      else if (fall & mode == WSS_PUSH_PULL)
         pp_second <= ~pp_second;
   end

   // ==========================================================
   // Waveform shaping, active high before polarity
   // ==========================================================
   // A pulse shorter than the count stays hidden behind the wait flag.
   wire hb_a  = wave & ~rise_wait & ~rise_trig;
   wire hb_b  = ~wave & ~fall_wait & ~fall_trig;
   wire fwd_d = wave & ~fall_wait & ~fall_trig;
   wire rev_b = wave & ~rise_wait & ~rise_trig;
   logic [3:0] raw;

   always_comb
   begin
      raw = 4'h0;
      unique case (mode)
         WSS_HALF:       raw = {hb_b, hb_a, hb_b, hb_a};
         WSS_PUSH_PULL:  raw = {wave & pp_second, wave & ~pp_second,
                                wave & pp_second, wave & ~pp_second};
         WSS_FWD_FULL,
         WSS_REV_FULL:   raw = dir_rev ? {1'b0, 1'b1, rev_b, 1'b0}
                                       : {fwd_d, 1'b0, 1'b0, 1'b1};
         WSS_STEER,
         WSS_SYNC_STEER: raw = {4{wave}};
         default:        raw = 4'h0;
      endcase
   end

   // ==========================================================
   // Output stage with override
   // ==========================================================
   logic [3:0] next_level;
   logic [3:0] next_oe;

   always_comb
   begin
      logic [1:0] field;
      logic       overridden;
      next_level = 4'h0;
      next_oe    = 4'h0;
      field      = 2'b00;
      overridden = 1'b0;
      for (int i = 0; i < NUM_OUT; i++)
      begin
         field      = (i % 2 == 1) ? ovr_bd : ovr_ac;
         overridden = override_on & (~is_steer | steer_act[i]);
         if (is_steer & ~steer_act[i])
            next_level[i] = steer[POS_FIXED + i];
         else
            next_level[i] = raw[i] ^ polarity[i];
         next_oe[i] = en & out_enable[i];
         if (overridden)
         begin
            unique case (field)
               OVR_ONE:      next_level[i] = 1'b1;
               OVR_ZERO:     next_level[i] = 1'b0;
               OVR_TRISTATE: next_oe[i]    = 1'b0;
               OVR_INACTIVE: next_level[i] = polarity[i];
            endcase
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         out_level_out <= 4'h0;
         out_oe_out    <= 4'h0;
      end
      else
      begin
         out_level_out <= next_level;
         out_oe_out    <= next_oe;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         osc_keep_request_out <= 1'b0;
      else
         osc_keep_request_out <= en & clk_hf;
   end

   // ==========================================================
   // Read data
   // ==========================================================
   logic [DATA_W-1:0] rdata;

   always_comb
   begin
      rdata = '0;
      if (hit_c0)
         rdata[7:0] = {en, load_req, 3'b000, mode};
      else if (hit_pol)
         rdata[7:0] = {2'b00, wave, 1'b0, polarity};
      else if (hit_rdb)
         rdata[DB_W-1:0] = rise_buf;
      else if (hit_fdb)
         rdata[DB_W-1:0] = fall_buf;
      else if (hit_sd0)
         rdata[7:0] = {sd_status, restart_en, ovr_bd, ovr_ac, 2'b00};
      else if (hit_sds)
         rdata[NUM_SD-1:0] = sd_select;
      else if (hit_str)
         rdata[7:0] = steer;
      else if (hit_oen)
         rdata[3:0] = out_enable;
      else if (hit_clk)
         rdata[0] = clk_hf;
      else if (hit_ism)
         rdata[SEL_W-1:0] = in_select;
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         prdata_out <= '0;
      else if (psel_in & ~penable_in & ~pwrite_in)
         prdata_out <= rdata;
   end

   assign pready_out  = 1'b1;
   assign pslverr_out = access & ~mapped;

endmodule : wss_top

`default_nettype wire

// ===== include/wss_pkg.sv
// Package for the waveform steering and shutdown output stage.
// Assumes a 32-bit APB register port and a single 250 MHz clock.
package wss_pkg;

   // ==========================================================
   // Bus and register map
   // ==========================================================
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_CONTROL0   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_POLARITY   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RISE_DB    = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FALL_DB    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_SD_CTRL0   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_SD_SOURCE  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STEER      = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_OUT_ENABLE = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_CLK_SELECT = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IN_SELECT  = 8'h24;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned BIT_EN       = 7;
   localparam int unsigned BIT_LD       = 6;
   localparam int unsigned BIT_IN       = 5;
   localparam int unsigned BIT_SHUTDOWN = 7;
   localparam int unsigned BIT_REN      = 6;
   localparam int unsigned POS_OVERRIDE_LEVEL_BD     = 4;
   localparam int unsigned POS_OVERRIDE_LEVEL_AC     = 2;
   localparam int unsigned POS_FIXED    = 4;
   localparam int unsigned DB_W         = 6;
   localparam int unsigned NUM_OUT      = 4;
   localparam int unsigned NUM_SD       = 6;
   localparam int unsigned NUM_WAVE     = 16;
   localparam int unsigned SEL_W        = 4;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [1:0]      RST_OVR_LEVEL = 2'h1;
   localparam logic [DB_W-1:0] RST_DB        = 6'h00;

   // ==========================================================
   // Mode and override encodings
   // ==========================================================
   typedef enum logic [2:0] {
      WSS_STEER      = 3'b000,
      WSS_SYNC_STEER = 3'b001,
      WSS_FWD_FULL   = 3'b010,
      WSS_REV_FULL   = 3'b011,
      WSS_HALF       = 3'b100,
      WSS_PUSH_PULL  = 3'b101,
      WSS_RSVD6      = 3'b110,
      WSS_RSVD7      = 3'b111
   } wss_mode_e;

   localparam logic [1:0] OVR_ONE      = 2'b11;
   localparam logic [1:0] OVR_ZERO     = 2'b10;
   localparam logic [1:0] OVR_TRISTATE = 2'b01;
   localparam logic [1:0] OVR_INACTIVE = 2'b00;

endpackage : wss_pkg

// ===== tb/wss_top_monitor.sv
// Checker for the waveform steering and shutdown stage.
// Sees only the top module ports; bound into wss_top below.
`timescale 1ns/1ps
`default_nettype none
module wss_top_monitor
   import wss_pkg::*;
(
   input wire logic                         clock_in,
   input wire logic                         rst_in,
   input wire logic                         psel_in,
   input wire logic                         penable_in,
   input wire logic                         pwrite_in,
   input wire logic [wss_pkg::ADDR_W-1:0]   paddr_in,
   input wire logic [wss_pkg::DATA_W-1:0]   pwdata_in,
   input wire logic [wss_pkg::DATA_W-1:0]   prdata_out,
   input wire logic                         pready_out,
   input wire logic                         pslverr_out,
   input wire logic [wss_pkg::NUM_WAVE-1:0] wave_sources_in,
   input wire logic [wss_pkg::NUM_SD-2:0]   shutdown_sources_n_in,
   input wire logic [wss_pkg::NUM_OUT-1:0]  out_level_out,
   input wire logic [wss_pkg::NUM_OUT-1:0]  out_oe_out,
   input wire logic                         osc_keep_request_out
);
   // ==========
   // Register shadows.
   logic       en, cks, ren, sw_sd;
   logic [2:0] mode;
   logic [1:0] ovr_bd, ovr_ac;
   logic [5:0] src;
   logic [3:0] oe, steer, fixd, low_cnt, quiet;
   wire wr = psel_in & penable_in & pwrite_in & pready_out;
   wire sd_hit = paddr_in == OFF_SD_CTRL0;
   wire rd_sd = psel_in & penable_in & !pwrite_in & sd_hit;
   wire sel_low = |(src[4:0] & ~shutdown_sources_n_in)
                  | (src[5] & ~wave_sources_in[0]);
   wire in_sd = sw_sd | (low_cnt > 4'h6);
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         {en, cks, ren, sw_sd, mode, src, oe, steer, fixd} <= '0;
         {ovr_bd, ovr_ac} <= 4'h5;
      end
      else if (wr)
      begin
         case (paddr_in)
            OFF_CONTROL0:   {en, mode} <= {pwdata_in[7], pwdata_in[2:0]};
            OFF_SD_CTRL0:   {sw_sd, ren, ovr_bd, ovr_ac} <=
                               {pwdata_in[7] & ~pwdata_in[6], pwdata_in[6:2]};
            OFF_SD_SOURCE:  src <= pwdata_in[5:0];
            OFF_STEER:      {fixd, steer} <= pwdata_in[7:0];
            OFF_OUT_ENABLE: oe <= pwdata_in[3:0];
            OFF_CLK_SELECT: cks <= pwdata_in[0];
            default:        ;
         endcase
      end
   end
   // Counts cycles of held fault and of quiet since the last fault or shutdown register write.
   always_ff @(posedge clock_in)
   begin
      if (rst_in || !sel_low)
         low_cnt <= 4'h0;
      else if (low_cnt != 4'hF)
         low_cnt <= low_cnt + 4'h1;
      if (rst_in || sel_low || (wr && sd_hit))
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   end
   // ==========
   // Properties.
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   property p_osc;
      $stable(en & cks) |-> osc_keep_request_out == (en & cks);
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator request wrong");
   property p_ovr_bd;
      (en && sel_low && ovr_bd[1] && mode[2:1] != 2'b00 && oe == 4'hF)[*6]
         |-> out_level_out[1] == ovr_bd[0] && out_level_out[3] == ovr_bd[0];
   endproperty
   a_ovr_bd: assert property (p_ovr_bd)
      else $error("b and d override wrong");
   property p_ovr_ac;
      (en && in_sd && ovr_ac[1] && mode[2:1] != 2'b00 && oe == 4'hF)[*4]
         |-> out_level_out[0] == ovr_ac[0] && out_level_out[2] == ovr_ac[0];
   endproperty
   a_ovr_ac: assert property (p_ovr_ac)
      else $error("a and c override wrong");
   property p_tri;
      (en && in_sd && ovr_bd == OVR_TRISTATE)[*3]
         |-> !out_oe_out[1] && !out_oe_out[3];
   endproperty
   a_tri: assert property (p_tri)
      else $error("b and d not released");
   property p_fixed;
      (en && mode == 3'b000 && oe == 4'hF && $stable(steer) && $stable(fixd))[*3]
         |-> ((out_level_out ^ fixd) & ~steer) == 4'h0;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed level wrong");
   property p_held;
      rd_sd && en && low_cnt > 4'h6 |-> prdata_out[7];
   endproperty
   a_held: assert property (p_held)
      else $error("shutdown cleared under fault");
   property p_sw;
      rd_sd && sw_sd |-> prdata_out[7];
   endproperty
   a_sw: assert property (p_sw)
      else $error("software shutdown lost");
   property p_auto;
      rd_sd && ren && quiet > 4'hA |-> !prdata_out[7];
   endproperty
   a_auto: assert property (p_auto)
      else $error("auto restart failed");
endmodule : wss_top_monitor
bind wss_top wss_top_monitor u_mon (
   .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .wave_sources_in(wave_sources_in),
   .shutdown_sources_n_in(shutdown_sources_n_in),
   .out_level_out(out_level_out), .out_oe_out(out_oe_out),
   .osc_keep_request_out(osc_keep_request_out));
`default_nettype wire

// ===== tb/wss_far_model.sv
// Far side model: waveform source and active-low fault lines.
// Assumes the bench commands it on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wss_far_model #(
   parameter int HI  = 20,
   parameter int PER = 40
)(
   input  wire logic        clock_in,
   input  wire logic        run_in,
   input  wire logic [4:0]  trip_n_in,
   output logic      [15:0] wave_out = 16'h0000,
   output logic      [4:0]  fault_n_out = 5'h1F
);
   logic [7:0] cnt = 8'h00;
   always @(posedge clock_in)
   begin
      cnt <= (!run_in || cnt == PER - 1) ? 8'h00 : cnt + 8'h01;
      wave_out <= {16{run_in && cnt < HI}};
      fault_n_out <= trip_n_in;
   end
endmodule : wss_far_model
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the waveform steering and shutdown stage.
// Drives APB and the far side model; the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import wss_pkg::*;
;
   logic        clock_in, rst_in, psel, pen, pwr, run, pready, pslverr, osc;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] wave;
   logic [4:0]  trip_n, flt_n;
   logic [3:0]  lvl, oe;
   int          n_errors, compares, n1, n2;
   initial
   begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   wss_top u_dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .wave_sources_in(wave),
      .shutdown_sources_n_in(flt_n), .out_level_out(lvl), .out_oe_out(oe),
      .osc_keep_request_out(osc));
   wss_far_model u_far (.clock_in(clock_in), .run_in(run),
      .trip_n_in(trip_n), .wave_out(wave), .fault_n_out(flt_n));
   // ==========
   // Tasks.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic er = 1'b0);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      pen <= 1'b1;
      @(posedge clock_in);
      while (pready !== 1'b1)
         @(posedge clock_in);
      if (!w)
         chk(prdata, d);
      chk(32'(pslverr), 32'(er));
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clock_in);
   endtask : acc
   task automatic wv(input logic v);
      while (wave[0] !== !v)
         @(posedge clock_in);
      while (wave[0] !== v)
         @(posedge clock_in);
   endtask : wv
   task automatic dbm(output int n);
      wv(1'b0);
      n = 0;
      while (lvl[1] !== 1'b1 && n < 60)
      begin
         @(posedge clock_in);
         n++;
      end
   endtask : dbm
   task automatic final_report;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   initial
   begin
      #100000;
      n_errors++;
      final_report;
   end
   // ==========
   // Main sequence.
   initial
   begin
      {psel, pen, pwr, run, rst_in} = 5'h01;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      trip_n = 5'h1F;
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      acc(0, OFF_SD_CTRL0, 32'h14);
      acc(0, 8'h3C, 32'h0, 1'b1);
      acc(1, OFF_CONTROL0, 32'h04);
      acc(1, OFF_FALL_DB, 32'h04);
      acc(0, OFF_FALL_DB, 32'h04);
      acc(1, OFF_RISE_DB, 32'h02);
      acc(1, OFF_SD_SOURCE, 32'h01);
      acc(1, OFF_SD_CTRL0, 32'h9C);
      acc(1, OFF_CLK_SELECT, 32'h01);
      acc(1, OFF_OUT_ENABLE, 32'h0F);
      acc(1, OFF_CONTROL0, 32'h84);
      run <= 1'b1;
      repeat (6) @(posedge clock_in);
      chk(32'(oe), 32'h5);
      chk(32'(lvl & 4'h5), 32'h5);
      chk(32'(osc), 32'h1);
      acc(0, OFF_SD_CTRL0, 32'h9C);
      acc(1, OFF_SD_CTRL0, 32'h2C);
      wv(1'b1);
      dbm(n1);
      acc(1, OFF_FALL_DB, 32'h08);
      acc(1, OFF_CONTROL0, 32'hC4);
      wv(1'b0);
      repeat (4) @(posedge clock_in);
      acc(0, OFF_CONTROL0, 32'h84);
      dbm(n2);
      chk(32'((n2 - n1) inside {[3:5]}), 32'h1);
      acc(1, OFF_FALL_DB, 32'h28);
      acc(1, OFF_CONTROL0, 32'hC4);
      wv(1'b0);
      dbm(n1);
      chk(32'(n1), 32'h3C);
      acc(1, OFF_CONTROL0, 32'h82);
      wv(1'b1);
      repeat (12) @(posedge clock_in);
      chk(32'(lvl & 4'h7), 32'h1);
      acc(1, OFF_CONTROL0, 32'h83);
      chk(32'(lvl & 4'h7), 32'h1);
      wv(1'b1);
      repeat (12) @(posedge clock_in);
      chk(32'(lvl), 32'h6);
      trip_n <= 5'h1E;
      repeat (8) @(posedge clock_in);
      chk(32'(lvl), 32'h5);
      acc(1, OFF_SD_CTRL0, 32'h2C);
      acc(0, OFF_SD_CTRL0, 32'hAC);
      trip_n <= 5'h1F;
      repeat (6) @(posedge clock_in);
      acc(1, OFF_SD_CTRL0, 32'h2C);
      acc(0, OFF_SD_CTRL0, 32'h2C);
      wv(1'b1);
      repeat (12) @(posedge clock_in);
      chk(32'(lvl), 32'h6);
      acc(1, OFF_SD_CTRL0, 32'h6C);
      trip_n <= 5'h1E;
      repeat (8) @(posedge clock_in);
      acc(0, OFF_SD_CTRL0, 32'hEC);
      trip_n <= 5'h1F;
      repeat (12) @(posedge clock_in);
      acc(0, OFF_SD_CTRL0, 32'h6C);
      wv(1'b1);
      repeat (12) @(posedge clock_in);
      chk(32'(lvl), 32'h6);
      acc(1, OFF_STEER, 32'hA1);
      acc(1, OFF_POLARITY, 32'h01);
      acc(1, OFF_CONTROL0, 32'h80);
      wv(1'b1);
      repeat (8) @(posedge clock_in);
      chk(32'(lvl), 32'hA);
      wv(1'b0);
      repeat (4) @(posedge clock_in);
      acc(1, OFF_STEER, 32'hA0);
      @(posedge clock_in);
      chk(32'(lvl), 32'hA);
      acc(1, OFF_STEER, 32'hA1);
      acc(1, OFF_CONTROL0, 32'h81);
      wv(1'b0);
      repeat (6) @(posedge clock_in);
      chk(32'(lvl), 32'hB);
      acc(1, OFF_STEER, 32'hA0);
      chk(32'(lvl), 32'hB);
      wv(1'b0);
      repeat (6) @(posedge clock_in);
      chk(32'(lvl), 32'hA);
      final_report;
   end
endmodule : tb_top
`default_nettype wire
